// *** core/ext_memory_pin_mux_pkg.sv ***
// package: encodings, field layout and pin indices of the memory pin group mux
package ext_memory_pin_mux_pkg;

	// ***********************************************
	// mode field values
	// ***********************************************
	localparam logic [2:0] MODE_GPIO_ONLY = 3'h0;
	localparam logic [2:0] MODE_ASYNC16   = 3'h2;
	localparam logic [2:0] MODE_NAND8     = 3'h5;

	// ***********************************************
	// pin group layout: index 0..49 = gp5..gp54, 50..57 = gp89..gp96
	// ***********************************************
	localparam int         PIN_COUNT      = 58;
	localparam int         LOW_GP_FIRST   = 5;
	localparam int         LOW_GP_LAST    = 54;
	localparam int         HIGH_GP_FIRST  = 89;
	localparam int         HIGH_GP_BASE   = 50;
	localparam int         COUNT_WIDTH    = 7;
	localparam logic [6:0] GPIO_MIN_OPT_C = 7'h0d;
	localparam logic [6:0] GPIO_RESET_CNT = 7'h3a;

	typedef enum logic [1:0] {
		FN_GPIO,
		FN_MEM,
		FN_PCI,
		FN_RMII
	} func_t;

	typedef enum logic [3:0] {
		OPT_A, OPT_B, OPT_C, OPT_D, OPT_E, OPT_F,
		OPT_G, OPT_H, OPT_J, OPT_K, OPT_UNLISTED
	} option_t;

	typedef struct packed {
		logic [2:0] memory_pin_mode;
		logic       pci_pin_enable;
		logic       rmii_select;
		logic       chip_select3_pin_choice;
		logic       chip_select4_pin_choice;
		logic       chip_select5_pin_choice;
	} config_t;

	typedef struct packed {
		func_t [PIN_COUNT-1:0] fn;
	} pin_map_t;

	localparam config_t CONFIG_RESET = '0;

	// position of a general io pin number in the pin map
	function automatic int gp_index(input int gp);
		return (gp <= LOW_GP_LAST) ? gp - LOW_GP_FIRST : gp - HIGH_GP_FIRST + HIGH_GP_BASE;
	endfunction

endpackage

// *** core/config_option_classifier.sv ***
// classifier: names the major configuration option selected by the fields
`timescale 1ns/1ps

module config_option_classifier
	import ext_memory_pin_mux_pkg::*;
(
	input  wire config_t cfg_in,
	output option_t      option_out
);

	logic no_cs45;

	always_comb begin
		no_cs45 = !cfg_in.chip_select4_pin_choice && !cfg_in.chip_select5_pin_choice;
		option_out = OPT_UNLISTED;
		case ({cfg_in.pci_pin_enable, cfg_in.memory_pin_mode})
			{1'b0, MODE_GPIO_ONLY}: begin
				if (cfg_in.chip_select3_pin_choice || !no_cs45)
					option_out = OPT_UNLISTED;
				else
					option_out = cfg_in.rmii_select ? OPT_B : OPT_A;
			end
			{1'b0, MODE_ASYNC16}: begin
				if (!cfg_in.rmii_select)
					option_out = OPT_C;
				else if (no_cs45)
					option_out = OPT_D;
			end
			{1'b0, MODE_NAND8}: begin
				if (!cfg_in.rmii_select)
					option_out = OPT_E;
				else if (no_cs45)
					option_out = OPT_F;
			end
			{1'b1, MODE_GPIO_ONLY}: begin
				if (cfg_in.chip_select3_pin_choice || !no_cs45)
					option_out = OPT_UNLISTED;
				else
					option_out = cfg_in.rmii_select ? OPT_H : OPT_G;
			end
			{1'b1, MODE_NAND8}: begin
				if (!cfg_in.rmii_select)
					option_out = OPT_J;
				else if (no_cs45)
					option_out = OPT_K;
			end
			default: begin
				option_out = OPT_UNLISTED;
			end
		endcase
	end

endmodule // config_option_classifier

// *** core/ext_memory_pin_mux.sv ***
// pin function multiplexer for the external memory pin group
//
// How it works
// - mode 2, no pci, no rmii: option C
// - chip select choice 1 routes its select, cs4/cs5 only with rmii off
// - chip select choice 0 gives general io, cs4/cs5 only with rmii off
// - option C: no pci, 16-bit, select 2
// - option C leaves at least thirteen io pins
// - mode 5 gives the 8-bit nand pinout
// - wait, output and write enables never muxed
// - sub-block 0 from mode, rmii, pci only
// - sub-block 1 from mode, selects, rmii
// - sub-block 3 from mode and pci only
`timescale 1ns/1ps

module ext_memory_pin_mux
	import ext_memory_pin_mux_pkg::*;
(
	input  wire logic             clk_in,
	input  wire logic             reset_n_in,
	input  wire logic [2:0]       memory_pin_mode_in,
	input  wire logic             pci_pin_enable_in,
	input  wire logic             rmii_select_in,
	input  wire logic             chip_select3_pin_choice_in,
	input  wire logic             chip_select4_pin_choice_in,
	input  wire logic             chip_select5_pin_choice_in,
	input  wire logic             memory_chip_select2_in,
	input  wire logic             memory_chip_select3_in,
	input  wire logic             memory_chip_select4_in,
	input  wire logic             memory_chip_select5_in,
	input  wire logic [3:0]       general_io_pin_in,
	output pin_map_t              pin_function_out,
	output option_t               config_option_out,
	output logic [COUNT_WIDTH-1:0] gpio_pin_count_out,
	output logic                  memory_control_fixed_out,
	output logic [3:0]            chip_select_pin_out
);

	// ***********************************************
	// field decode
	// ***********************************************
	config_t  cfg;
	option_t  option;
	pin_map_t map;

	assign cfg = '{memory_pin_mode: memory_pin_mode_in, pci_pin_enable: pci_pin_enable_in,
		rmii_select: rmii_select_in, chip_select3_pin_choice: chip_select3_pin_choice_in,
		chip_select4_pin_choice: chip_select4_pin_choice_in,
		chip_select5_pin_choice: chip_select5_pin_choice_in};

	config_option_classifier classifier (
		.cfg_in     (cfg),
		.option_out (option)
	);

	function automatic logic is_async16(input logic [2:0] mode);
		return mode == MODE_ASYNC16;
	endfunction

	function automatic logic is_any_mem(input logic [2:0] mode);
		return (mode == MODE_ASYNC16) || (mode == MODE_NAND8);
	endfunction

	// shared address pins: memory, pci or general io
	function automatic func_t addr_pin(input logic [2:0] mode, input logic pci);
		if (pci)
			return FN_PCI;
		return is_async16(mode) ? FN_MEM : FN_GPIO;
	endfunction

	// optional chip select pin, possibly rmii receive data
	function automatic func_t cs_pin(input logic rmii, input logic choice);
		if (rmii)
			return FN_RMII;
		return choice ? FN_MEM : FN_GPIO;
	endfunction

	function automatic logic [COUNT_WIDTH-1:0] count_gpio(input pin_map_t m);
		logic [COUNT_WIDTH-1:0] n;
		n = '0;
		for (int i = 0; i < PIN_COUNT; i++)
			n = n + COUNT_WIDTH'(m.fn[i] == FN_GPIO);
		return n;
	endfunction

	// ***********************************************
	// per pin function
	// ***********************************************
	always_comb begin
		map = '0;
		// sub-block 0
		for (int gp = 34; gp <= 43; gp++)
			map.fn[gp_index(gp)] = is_async16(cfg.memory_pin_mode) ? FN_MEM : FN_GPIO;
		for (int gp = 44; gp <= 51; gp++)
			map.fn[gp_index(gp)] = addr_pin(cfg.memory_pin_mode, cfg.pci_pin_enable);
		map.fn[gp_index(52)] = cfg.rmii_select ? FN_RMII : FN_GPIO;
		// sub-block 1
		map.fn[gp_index(33)] = cs_pin(cfg.rmii_select, cfg.chip_select5_pin_choice);
		map.fn[gp_index(32)] = cs_pin(cfg.rmii_select, cfg.chip_select4_pin_choice);
		for (int gp = 27; gp <= 31; gp++)
			map.fn[gp_index(gp)] = cfg.rmii_select ? FN_RMII : FN_GPIO;
		for (int gp = 14; gp <= 21; gp++)
			map.fn[gp_index(gp)] = is_any_mem(cfg.memory_pin_mode) ? FN_MEM : FN_GPIO;
		map.fn[gp_index(13)] = cfg.chip_select3_pin_choice ? FN_MEM : FN_GPIO;
		map.fn[gp_index(12)] = is_any_mem(cfg.memory_pin_mode) ? FN_MEM : FN_GPIO;
		for (int gp = 8; gp <= 9; gp++)
			map.fn[gp_index(gp)] = is_any_mem(cfg.memory_pin_mode) ? FN_MEM : FN_GPIO;
		for (int gp = 10; gp <= 11; gp++)
			map.fn[gp_index(gp)] = is_async16(cfg.memory_pin_mode) ? FN_MEM : FN_GPIO;
		for (int gp = 5; gp <= 7; gp++)
			map.fn[gp_index(gp)] = is_async16(cfg.memory_pin_mode) ? FN_MEM : FN_GPIO;
		// sub-block 3
		for (int gp = 89; gp <= 96; gp++)
			map.fn[gp_index(gp)] = addr_pin(cfg.memory_pin_mode, cfg.pci_pin_enable);
	end

	// ***********************************************
	// output registers
	// ***********************************************
	pin_map_t               next_pin_function;
	option_t                next_config_option;
	logic [COUNT_WIDTH-1:0] next_gpio_pin_count;
	logic [3:0]             next_chip_select_pin;

	always_comb begin
		next_pin_function   = map;
		next_config_option  = option;
		next_gpio_pin_count = count_gpio(map);
		// chip select 2 shares the nand and async data mode decode
		next_chip_select_pin[0] = (map.fn[gp_index(12)] == FN_MEM) ? memory_chip_select2_in : general_io_pin_in[0];
		next_chip_select_pin[1] = (map.fn[gp_index(13)] == FN_MEM) ? memory_chip_select3_in : general_io_pin_in[1];
		next_chip_select_pin[2] = (map.fn[gp_index(32)] == FN_MEM) ? memory_chip_select4_in : general_io_pin_in[2];
		next_chip_select_pin[3] = (map.fn[gp_index(33)] == FN_MEM) ? memory_chip_select5_in : general_io_pin_in[3];
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_function_out         <= '0;
			config_option_out        <= OPT_A;
			gpio_pin_count_out       <= GPIO_RESET_CNT;
			memory_control_fixed_out <= 1'b1;
			chip_select_pin_out      <= 4'h0;
		end else begin
			pin_function_out         <= next_pin_function;
			config_option_out        <= next_config_option;
			gpio_pin_count_out       <= next_gpio_pin_count;
			memory_control_fixed_out <= 1'b1;
			chip_select_pin_out      <= next_chip_select_pin;
		end
	end

	// ***********************************************
	// checks
	// ***********************************************
	logic any_pci_out;

	always_comb begin
		any_pci_out = 1'b0;
		for (int i = 0; i < PIN_COUNT; i++)
			any_pci_out = any_pci_out | (pin_function_out.fn[i] == FN_PCI);
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	option_c_decode_a: assert property (
		(!pci_pin_enable_in && memory_pin_mode_in == MODE_ASYNC16 && !rmii_select_in)
		|=> config_option_out == OPT_C)
		else $error("option C not decoded");

	cs_route_a: assert property (
		chip_select3_pin_choice_in
		|=> pin_function_out.fn[gp_index(13)] == FN_MEM && chip_select_pin_out[1] == $past(memory_chip_select3_in))
		else $error("chip select 3 not routed");

	cs_release_a: assert property (
		(!chip_select5_pin_choice_in && !rmii_select_in)
		|=> pin_function_out.fn[gp_index(33)] == FN_GPIO && chip_select_pin_out[3] == $past(general_io_pin_in[3]))
		else $error("chip select 5 pin not released");

	option_c_pins_a: assert property (
		config_option_out == OPT_C
		|-> !any_pci_out && pin_function_out.fn[gp_index(12)] == FN_MEM
			&& pin_function_out.fn[gp_index(36)] == FN_MEM)
		else $error("option C pinout wrong");

	option_c_gpio_a: assert property (
		config_option_out == OPT_C |-> gpio_pin_count_out >= GPIO_MIN_OPT_C)
		else $error("too few io pins in option C");

	nand_pinout_a: assert property (
		memory_pin_mode_in == MODE_NAND8
		|=> pin_function_out.fn[gp_index(14)] == FN_MEM && pin_function_out.fn[gp_index(8)] == FN_MEM
			&& pin_function_out.fn[gp_index(11)] == FN_GPIO && pin_function_out.fn[gp_index(43)] == FN_GPIO)
		else $error("nand pinout wrong");

	control_fixed_a: assert property (
		memory_control_fixed_out == 1'b1)
		else $error("memory control pins muxed");

	sub0_rmii_a: assert property (
		$past(reset_n_in) && $stable(memory_pin_mode_in) && $stable(rmii_select_in) && $stable(pci_pin_enable_in)
		|=> $stable(pin_function_out.fn[gp_index(52)]) && $stable(pin_function_out.fn[gp_index(44)]))
		else $error("sub-block 0 changed without its fields");

	sub1_select_a: assert property (
		rmii_select_in |=> pin_function_out.fn[gp_index(32)] == FN_RMII
			&& pin_function_out.fn[gp_index(29)] == FN_RMII)
		else $error("sub-block 1 rmii pins wrong");

	sub3_pci_a: assert property (
		(!pci_pin_enable_in && memory_pin_mode_in != MODE_ASYNC16)
		|=> pin_function_out.fn[gp_index(92)] == FN_GPIO)
		else $error("sub-block 3 decode wrong");

	pci_address_a: assert property (
		pci_pin_enable_in |=> pin_function_out.fn[gp_index(48)] == FN_PCI
			&& pin_function_out.fn[gp_index(89)] == FN_PCI)
		else $error("pci not on address pins");

endmodule // ext_memory_pin_mux

// *** sim/ext_memory_pin_mux_tb.sv ***
// testbench: table of pin group configurations checked at the mux outputs
`timescale 1ns/1ps

module ext_memory_pin_mux_tb
	import ext_memory_pin_mux_pkg::*;
;
	typedef struct packed {
		logic [7:0] c;
		option_t    o;
		logic [6:0] n;
		logic [3:0] cs;
		logic [6:0] p0;
		func_t      f0;
		logic [6:0] p1;
		func_t      f1;
	} row_t;

	logic                   clk_in     = 1'b0;
	logic                   reset_n_in = 1'b0;
	config_t                cfg        = CONFIG_RESET;
	logic [3:0]             mem_cs     = 4'h5;
	logic [3:0]             gio        = 4'ha;
	pin_map_t               pin_fn;
	option_t                opt;
	logic [COUNT_WIDTH-1:0] gp_count;
	logic                   ctl_fixed;
	logic [3:0]             cs_pins;
	int                     fail_count = 0;
	int                     n_compared = 0;
	row_t                   rows [16];

	always #2 clk_in = ~clk_in;

	ext_memory_pin_mux i_dut (
		.clk_in                     (clk_in),
		.reset_n_in                 (reset_n_in),
		.memory_pin_mode_in         (cfg.memory_pin_mode),
		.pci_pin_enable_in          (cfg.pci_pin_enable),
		.rmii_select_in             (cfg.rmii_select),
		.chip_select3_pin_choice_in (cfg.chip_select3_pin_choice),
		.chip_select4_pin_choice_in (cfg.chip_select4_pin_choice),
		.chip_select5_pin_choice_in (cfg.chip_select5_pin_choice),
		.memory_chip_select2_in     (mem_cs[0]),
		.memory_chip_select3_in     (mem_cs[1]),
		.memory_chip_select4_in     (mem_cs[2]),
		.memory_chip_select5_in     (mem_cs[3]),
		.general_io_pin_in          (gio),
		.pin_function_out           (pin_fn),
		.config_option_out          (opt),
		.gpio_pin_count_out         (gp_count),
		.memory_control_fixed_out   (ctl_fixed),
		.chip_select_pin_out        (cs_pins)
	);

	// ***********************************************
	// compare and drive tasks
	// ***********************************************
	task automatic check_bits(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_opt(input option_t got, input option_t exp);
		check_bits({4'h0, got}, {4'h0, exp});
	endtask

	task automatic check_fn(input logic [6:0] gp, input func_t exp);
		int idx;
		idx = (gp <= 7'h36) ? int'(gp) - 5 : int'(gp) - 39;
		check_bits({6'h00, pin_fn.fn[idx]}, {6'h00, exp});
	endtask

	task automatic apply(input logic [7:0] c);
		@(posedge clk_in);
		#1;
		cfg = config_t'(c);
		@(posedge clk_in);
		#1;
	endtask

	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ***********************************************
	// main sequence
	// ***********************************************
	initial begin
		// cfg: mode[2:0] pci rmii cs3 cs4 cs5
		rows[0]  = '{8'h00, OPT_A, 7'h3a, 4'ha, 7'h60, FN_GPIO, 7'h05, FN_GPIO};
		rows[1]  = '{8'h08, OPT_B, 7'h32, 4'ha, 7'h34, FN_RMII, 7'h21, FN_RMII};
		rows[2]  = '{8'h45, OPT_C, 7'h0e, 4'h1, 7'h0d, FN_MEM, 7'h20, FN_GPIO};
		rows[3]  = '{8'h47, OPT_C, 7'h0d, 4'h5, 7'h21, FN_MEM, 7'h59, FN_MEM};
		rows[4]  = '{8'h40, OPT_C, 7'h10, 4'hb, 7'h0d, FN_GPIO, 7'h05, FN_MEM};
		rows[5]  = '{8'h4c, OPT_D, 7'h07, 4'h9, 7'h1f, FN_RMII, 7'h0d, FN_MEM};
		rows[6]  = '{8'ha7, OPT_E, 7'h2c, 4'h5, 7'h09, FN_MEM, 7'h0b, FN_GPIO};
		rows[7]  = '{8'ha2, OPT_E, 7'h2e, 4'hf, 7'h20, FN_MEM, 7'h2b, FN_GPIO};
		rows[8]  = '{8'ha8, OPT_F, 7'h27, 4'hb, 7'h08, FN_MEM, 7'h34, FN_RMII};
		rows[9]  = '{8'h10, OPT_G, 7'h2a, 4'ha, 7'h30, FN_PCI, 7'h60, FN_PCI};
		rows[10] = '{8'h18, OPT_H, 7'h22, 4'ha, 7'h59, FN_PCI, 7'h1e, FN_RMII};
		rows[11] = '{8'hb0, OPT_J, 7'h1f, 4'hb, 7'h2c, FN_PCI, 7'h15, FN_MEM};
		rows[12] = '{8'hbc, OPT_K, 7'h16, 4'h9, 7'h0c, FN_MEM, 7'h33, FN_PCI};
		rows[13] = '{8'h50, OPT_UNLISTED, 7'h10, 4'hb, 7'h33, FN_PCI, 7'h2b, FN_MEM};
		rows[14] = '{8'h4a, OPT_UNLISTED, 7'h08, 4'hb, 7'h20, FN_RMII, 7'h0a, FN_MEM};
		rows[15] = '{8'h60, OPT_UNLISTED, 7'h3a, 4'ha, 7'h0e, FN_GPIO, 7'h05, FN_GPIO};
		repeat (12) @(posedge clk_in);
		#1;
		check_opt(opt, OPT_A);
		check_bits({1'b0, gp_count}, {1'b0, GPIO_RESET_CNT});
		check_bits({7'h00, ctl_fixed}, 8'h01);
		check_bits({4'h0, cs_pins}, 8'h00);
		reset_n_in = 1'b1;
		// legal rows keep cs4/cs5 clear while rmii is on
		for (int i = 0; i < 16; i++) begin
			apply(rows[i].c);
			check_opt(opt, rows[i].o);
			check_bits({1'b0, gp_count}, {1'b0, rows[i].n});
			check_bits({4'h0, cs_pins}, {4'h0, rows[i].cs});
			check_fn(rows[i].p0, rows[i].f0);
			check_fn(rows[i].p1, rows[i].f1);
			check_bits({7'h00, ctl_fixed}, 8'h01);
		end
		// asynchronous reset in mid-run, then recovery
		@(posedge clk_in);
		#1;
		reset_n_in = 1'b0;
		#1;
		check_bits({1'b0, gp_count}, {1'b0, GPIO_RESET_CNT});
		check_fn(7'h0d, FN_GPIO);
		@(posedge clk_in);
		#1;
		reset_n_in = 1'b1;
		apply(rows[2].c);
		check_opt(opt, OPT_C);
		check_bits({4'h0, cs_pins}, 8'h01);
		// swapped select and io levels: each pin follows its own source
		mem_cs = 4'ha;
		gio    = 4'h5;
		apply(rows[3].c);
		check_bits({4'h0, cs_pins}, 8'h0a);
		apply(rows[0].c);
		check_bits({4'h0, cs_pins}, 8'h05);
		tally_and_finish();
	end

endmodule // ext_memory_pin_mux_tb
